// file: hdl/csr_params.svh
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
// Register map
`define CSR_STATUS_ADDR 6'h00
`define CSR_MODE_ADDR 6'h01
`define CSR_DATA_ADDR 6'h04
`define CSR_STATUS_RESET 8'h80
// Status field positions
`define CSR_BIT_READY 7
`define CSR_BIT_CONV_ERR 6
`define CSR_BIT_CKSUM_ERR 5
`define CSR_BIT_INTEG_ERR 4
`define CSR_BIT_RSVD 3
`define CSR_CHAN_MSB 2
// Result saturation values
`define CSR_RESULT_MAX 24'hffffff
`define CSR_RESULT_MIN 24'h000000
`endif

// file: hdl/csr_pkg.sv
package csr_pkg;
  // One result handed over by the conversion engine
  typedef struct packed {
    logic [23:0] value;
    logic overrange;
    logic underrange;
    logic [2:0] channel;
  } csr_result_t;
  // One register access decoded by the serial port
  typedef struct packed {
    logic is_write;
    logic [5:0] addr;
    logic cksum_bad;
  } csr_access_t;
endpackage

// file: hdl/csr_status.sv
// Summary of operation
// - Ready flag drives data-out/ready pin when chip select low and no read.
// - Ready bit 7 low on new result written; high means awaiting result.
// - In calibration modes ready goes low when calibration result written.
// - Reading the data register returns ready high.
// - Bit 6 set when a conversion is over or under range.
// - Overrange result saturates to all ones, underrange to all zeros.
// - Error bit refreshed only on result write; clears at next clean result.
// - Bit 5 set when a register write has a failing checksum.
// - Reading the status register clears the checksum error bit.
// - Bit 4 set when integrity mismatch reported while check active.
// - Clearing the check-enable bit clears the integrity error bit.
// - Bits 2..0 give channel of the value now in data register.
// - Channel field is the channel number in plain binary.
// - With append-status set, status byte follows each data read.
// - Status is 8 bits at 0x00, resets to 0x80, bit 3 reads 0.
// - A converter mode register write resets the ready flag.
`timescale 1ns/1ns
`include "csr_params.svh"
module csr_status #(
  parameter int RESULT_W = 24
) (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic RESULT_WR_IN,
  input wire csr_pkg::csr_result_t RESULT_IN,
  input wire logic ACCESS_IN,
  input wire csr_pkg::csr_access_t ACCESS_DATA_IN,
  input wire logic READ_ACTIVE_IN,
  input wire logic CS_N_IN,
  input wire logic INTEG_MISMATCH_IN,
  input wire logic INTEG_CHECK_EN_IN,
  input wire logic APPEND_STATUS_EN_IN,
  output logic [7:0] STATUS_OUT,
  output logic [23:0] DATA_OUT,
  output logic APPEND_STATUS_OUT,
  output logic DOUT_READY_OUT,
  output logic DOUT_READY_OE_OUT
);
  import csr_pkg::*;

  // Only the full result width is served
  if (RESULT_W != 24) begin : g_width_check
    $error("RESULT_W must be 24");
  end
  // Reset image of the status byte
  localparam logic [7:0] status_rst = `CSR_STATUS_RESET;

  ////////////////////////////////////////////////////////////
  // Access decode
  logic rd_status;
  logic rd_data;
  logic wr_mode;
  logic wr_any;
  assign rd_status = ACCESS_IN && !ACCESS_DATA_IN.is_write && ACCESS_DATA_IN.addr == `CSR_STATUS_ADDR;
  assign rd_data = ACCESS_IN && !ACCESS_DATA_IN.is_write && ACCESS_DATA_IN.addr == `CSR_DATA_ADDR;
  assign wr_mode = ACCESS_IN && ACCESS_DATA_IN.is_write && ACCESS_DATA_IN.addr == `CSR_MODE_ADDR;
  assign wr_any = ACCESS_IN && ACCESS_DATA_IN.is_write;

  ////////////////////////////////////////////////////////////
  // Status flags
  logic ready_ff;
  logic conv_err_ff;
  logic cksum_err_ff;
  logic integ_err_ff;
  logic [2:0] chan_ff;
  logic [23:0] data_ff;
  logic append_ff;

  // Ready flag; result write wins over the data-read and mode-write sets
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      ready_ff <= status_rst[`CSR_BIT_READY];
    end else if (RESULT_WR_IN) begin
      ready_ff <= 1'b0;
    end else if (rd_data || wr_mode) begin
      ready_ff <= 1'b1;
    end
  end

  // Conversion error, channel and saturated data
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      conv_err_ff <= 1'b0;
      chan_ff <= 3'h0;
      data_ff <= `CSR_RESULT_MIN;
    end else if (RESULT_WR_IN) begin
      conv_err_ff <= RESULT_IN.overrange || RESULT_IN.underrange;
      chan_ff <= RESULT_IN.channel;
      if (RESULT_IN.overrange) begin
        data_ff <= `CSR_RESULT_MAX;
      end else if (RESULT_IN.underrange) begin
        data_ff <= `CSR_RESULT_MIN;
      end else begin
        data_ff <= RESULT_IN.value;
      end
    end
  end

  // Checksum error; a set in the same cycle beats the read clear
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      cksum_err_ff <= 1'b0;
    end else if (wr_any && ACCESS_DATA_IN.cksum_bad) begin
      cksum_err_ff <= 1'b1;
    end else if (rd_status) begin
      cksum_err_ff <= 1'b0;
    end
  end

  // Integrity error
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      integ_err_ff <= 1'b0;
    end else if (!INTEG_CHECK_EN_IN) begin
      integ_err_ff <= 1'b0;
    end else if (INTEG_MISMATCH_IN) begin
      integ_err_ff <= 1'b1;
    end
  end

  // Append flag sampled with each data read
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      append_ff <= 1'b0;
    end else if (rd_data) begin
      append_ff <= APPEND_STATUS_EN_IN;
    end else begin
      append_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs
  // byte layout, bit 3 zero
  always_comb begin
    STATUS_OUT = 8'h00;
    STATUS_OUT[`CSR_BIT_READY] = ready_ff;
    STATUS_OUT[`CSR_BIT_CONV_ERR] = conv_err_ff;
    STATUS_OUT[`CSR_BIT_CKSUM_ERR] = cksum_err_ff;
    STATUS_OUT[`CSR_BIT_INTEG_ERR] = integ_err_ff;
    STATUS_OUT[`CSR_CHAN_MSB:0] = chan_ff;
  end
  assign DATA_OUT = data_ff;
  assign APPEND_STATUS_OUT = append_ff;
  assign DOUT_READY_OE_OUT = !CS_N_IN && !READ_ACTIVE_IN;
  assign DOUT_READY_OUT = ready_ff;

  ////////////////////////////////////////////////////////////
  // Checks
  AST_RDY_LOW: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    RESULT_WR_IN |=> !STATUS_OUT[7]) else $error("ready not low after result");
  AST_RDY_HIGH: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (rd_data && !RESULT_WR_IN) |=> STATUS_OUT[7]) else $error("ready not high after data read");
  AST_MODE_WR: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (wr_mode && !RESULT_WR_IN) |=> STATUS_OUT[7]) else $error("mode write kept ready low");
  AST_CONV_ERR: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !RESULT_WR_IN |=> $stable(STATUS_OUT[6])) else $error("error flag changed without result");
  AST_SAT: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (RESULT_WR_IN && RESULT_IN.overrange) |=> DATA_OUT == `CSR_RESULT_MAX && STATUS_OUT[6])
    else $error("overrange not saturated");
  AST_CKSUM: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (rd_status && !(wr_any && ACCESS_DATA_IN.cksum_bad)) |=> !STATUS_OUT[5]) else $error("checksum flag not cleared");
  AST_CKSUM_SET: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (wr_any && ACCESS_DATA_IN.cksum_bad) |=> STATUS_OUT[5]) else $error("checksum flag not set");
  AST_INTEG: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !INTEG_CHECK_EN_IN |=> !STATUS_OUT[4]) else $error("integrity flag not cleared");
  AST_CHAN: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    RESULT_WR_IN |=> STATUS_OUT[2:0] == $past(RESULT_IN.channel)) else $error("channel wrong");
  AST_PIN: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    DOUT_READY_OE_OUT |-> (DOUT_READY_OUT == STATUS_OUT[7] && !READ_ACTIVE_IN)) else $error("pin wrong");
  AST_RSVD: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !STATUS_OUT[3]) else $error("reserved bit set");
  // Clean result passes through and clears the error
  AST_DATA_PASS: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (RESULT_WR_IN && !RESULT_IN.overrange && !RESULT_IN.underrange)
    |=> DATA_OUT == $past(RESULT_IN.value) && !STATUS_OUT[6]) else $error("clean result not passed");
  // Underrange clamps to zero
  AST_SAT_LOW: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (RESULT_WR_IN && !RESULT_IN.overrange && RESULT_IN.underrange)
    |=> DATA_OUT == `CSR_RESULT_MIN && STATUS_OUT[6])
    else $error("underrange not saturated");
  // Only a bad write can raise the checksum flag
  AST_CKSUM_HOLD: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (!(wr_any && ACCESS_DATA_IN.cksum_bad) && !STATUS_OUT[5]) |=> !STATUS_OUT[5])
    else $error("checksum flag set without bad write");
  // Mismatch while enabled raises the integrity flag
  AST_INTEG_SET: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (INTEG_CHECK_EN_IN && INTEG_MISMATCH_IN) |=> STATUS_OUT[4]) else $error("integrity flag not set");
  // Append pulse follows a data read only
  AST_APPEND: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    rd_data |=> APPEND_STATUS_OUT == $past(APPEND_STATUS_EN_IN)) else $error("append pulse wrong");
  AST_APPEND_OFF: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !rd_data |=> !APPEND_STATUS_OUT) else $error("append pulse without data read");
  // Plain writes leave all status bits except integrity bit 4 alone
  AST_READ_ONLY: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (wr_any && !ACCESS_DATA_IN.cksum_bad && !wr_mode && !RESULT_WR_IN)
    |=> $stable(STATUS_OUT[7:5]) && $stable(STATUS_OUT[2:0])) else $error("write changed status");
  // Pin released when deselected or reading
  AST_PIN_OFF: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (CS_N_IN || READ_ACTIVE_IN) |-> !DOUT_READY_OE_OUT) else $error("pin driven while released");
  // Reset image right after any reset cycle
  AST_RST: assert property (@(posedge MCLK_IN)
    $past(RESET_IN) |-> STATUS_OUT == `CSR_STATUS_RESET && DATA_OUT == `CSR_RESULT_MIN && !APPEND_STATUS_OUT)
    else $error("reset value wrong");
endmodule

// file: bench/csr_host_model.sv
`timescale 1ns/1ns
// Host side: one decoded register access per call
module csr_host_model (
  input wire logic clk_in,
  output csr_pkg::csr_access_t acc_out,
  output logic acc_vld_out,
  output logic rd_act_out
);
  import csr_pkg::*;
  initial begin
    acc_out = '0;
    acc_vld_out = 1'b0;
    rd_act_out = 1'b0;
  end
  task automatic access(input logic wr, input logic [5:0] a, input logic bad);
    @(posedge clk_in);
    #1;
    acc_out = '{wr, a, bad};
    acc_vld_out = 1'b1;
    rd_act_out = !wr;
    @(posedge clk_in);
    #1;
    acc_vld_out = 1'b0;
    rd_act_out = 1'b0;
  endtask
endmodule

// file: bench/csr_status_tb_top.sv
`timescale 1ns/1ns
module csr_status_tb_top;
  import csr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic res_wr = 1'b0;
  csr_result_t res = '0;
  logic mism = 1'b0;
  logic app_en = 1'b0;
  logic cs_n = 1'b1;
  logic integ_en = 1'b0;
  csr_access_t acc;
  logic acc_vld, rd_act, app, rdy, oe;
  logic [7:0] st;
  logic [23:0] data;
  int errors = 0;
  int n_tests = 0;
  // Clock and watchdog
  always #2 clk = ~clk;
  initial begin
    #100000;
    errors++;
    final_report();
  end
  csr_host_model i_csr_host_model (.clk_in(clk), .acc_out(acc), .acc_vld_out(acc_vld), .rd_act_out(rd_act));
  csr_status i_csr_status (.MCLK_IN(clk), .RESET_IN(rst), .RESULT_WR_IN(res_wr), .RESULT_IN(res),
    .ACCESS_IN(acc_vld), .ACCESS_DATA_IN(acc), .READ_ACTIVE_IN(rd_act), .CS_N_IN(cs_n),
    .INTEG_MISMATCH_IN(mism), .INTEG_CHECK_EN_IN(integ_en), .APPEND_STATUS_EN_IN(app_en),
    .STATUS_OUT(st), .DATA_OUT(data), .APPEND_STATUS_OUT(app), .DOUT_READY_OUT(rdy), .DOUT_READY_OE_OUT(oe));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic put(input logic [23:0] v, input logic o, input logic u, input logic [2:0] c);
    @(posedge clk);
    #1;
    res = '{v, o, u, c};
    res_wr = 1'b1;
    @(posedge clk);
    #1;
    res_wr = 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("status", st, 8'h80);
    put(24'h123456, 1'b1, 1'b0, 3'd5);
    chk("status", st, 8'h45);
    chk("data", data, 24'hffffff);
    put(24'h123456, 1'b0, 1'b1, 3'd2);
    chk("data", data, 24'h000000);
    chk("status", st, 8'h42);
    for (int c = 0; c < 8; c++) begin
      put(24'h000100 + c, 1'b0, 1'b0, c[2:0]);
      chk("status", st, {5'h00, c[2:0]});
      chk("data", data, 24'h000100 + c);
    end
    app_en = 1'b1;
    i_csr_host_model.access(1'b0, 6'h04, 1'b0);
    chk("append", app, 1'b1);
    chk("ready", st[7], 1'b1);
    @(posedge clk);
    #1;
    chk("append", app, 1'b0);
    app_en = 1'b0;
    i_csr_host_model.access(1'b0, 6'h04, 1'b0);
    chk("append", app, 1'b0);
    cs_n = 1'b0;
    #1;
    chk("oe", oe, 1'b1);
    put(24'h000200, 1'b0, 1'b0, 3'd7);
    chk("pin", rdy, 1'b0);
    fork
      i_csr_host_model.access(1'b1, 6'h01, 1'b0);
      begin
        @(posedge clk);
        #2;
        chk("oe", oe, 1'b1);
      end
    join
    chk("status", st, 8'h87);
    chk("pin", rdy, 1'b1);
    fork
      i_csr_host_model.access(1'b0, 6'h01, 1'b1);
      begin
        @(posedge clk);
        #2;
        chk("oe", oe, 1'b0);
      end
    join
    chk("status", st, 8'h87);
    i_csr_host_model.access(1'b1, 6'h00, 1'b0);
    chk("status", st, 8'h87);
    i_csr_host_model.access(1'b1, 6'h00, 1'b1);
    chk("status", st, 8'ha7);
    i_csr_host_model.access(1'b0, 6'h00, 1'b0);
    chk("status", st, 8'h87);
    mism = 1'b1;
    @(posedge clk);
    #1;
    chk("integ", st[4], 1'b0);
    integ_en = 1'b1;
    mism = 1'b1;
    @(posedge clk);
    #1;
    mism = 1'b0;
    @(posedge clk);
    #1;
    chk("integ", st[4], 1'b1);
    integ_en = 1'b0;
    @(posedge clk);
    #1;
    chk("integ", st[4], 1'b0);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk("status", st, 8'h80);
    chk("data", data, 24'h000000);
    final_report();
  end
endmodule
